// [logic/sse_bank.sv]
// Sequence stack entries 28 to 31 with an APB slave and the stepping sequencer.
// Assumes conv_start and conv_done are one-cycle pulses synchronous to pclk.
//
// Behaviour
// - Bit 15 set means write, clear means read.
// - Bits 14-9 must hold the entry's own address.
// - Return bit clear: step to next entry.
// - Return bit set: step back to first entry.
// - Bits 7-4 select converter B channel.
// - Bits 3-0 select converter A channel.
// - Reset reads own address, other bits zero.
// - Entries decoded at indices 0x3c to 0x3f.
// - Both converters sample their channels together.
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
module sse_bank (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Conversion control.
   input wire logic conv_start,
   input wire logic conv_done,
   output logic sample_both,
   output logic [3:0] chan_a,
   output logic [3:0] chan_b,
   output logic conv_busy,
   output logic [1:0] active_entry
);
   import sse_pkg::*;

   sse_entry_if ent[SSE_NUM_ENTRIES] ();
   logic [15:0] word [SSE_NUM_ENTRIES];

   genvar gi;
   generate
      for (gi = 0; gi < SSE_NUM_ENTRIES; gi++) begin : g_ent
         sse_entry #(
            .SELF_ADDR(6'(SSE_IDX_E28 + 6'(gi)))
         ) u_entry (
            .pclk(pclk),
            .presetn(presetn),
            .port(ent[gi])
         );
         assign word[gi] = ent[gi].word;
      end
   endgenerate

   // Address decode.
   logic hit;
   logic [1:0] hit_idx;

   always_comb begin
      hit = 1'b0;
      hit_idx = 2'h0;
      if (paddr == SSE_ADDR_E28) begin
         hit = 1'b1;
         hit_idx = 2'h0;
      end else if (paddr == SSE_ADDR_E29) begin
         hit = 1'b1;
         hit_idx = 2'h1;
      end else if (paddr == SSE_ADDR_E30) begin
         hit = 1'b1;
         hit_idx = 2'h2;
      end else if (paddr == SSE_ADDR_E31) begin
         hit = 1'b1;
         hit_idx = 2'h3;
      end
   end

   logic setup;
   logic access;
   logic addr_ok;
   logic wr_frame;

   assign setup = psel && !penable;
   assign access = psel && penable && pready;
   // The self address equals the register index, so it is checked against paddr directly.
   assign addr_ok = (pwdata[SSE_ADDR_HI:SSE_ADDR_LO] == paddr[7:2]);
   assign wr_frame = pwdata[SSE_DIR_BIT];

   // Write strobes go to the entries only at the completing access edge.
   generate
      for (gi = 0; gi < SSE_NUM_ENTRIES; gi++) begin : g_wr
         assign ent[gi].wr = access && pwrite && hit && (hit_idx == 2'(gi))
                             && wr_frame && addr_ok;
         assign ent[gi].wdata = pwdata[SSE_RET_BIT:0];
      end
   endgenerate

   // APB answer: one access cycle, data and error prepared during setup.
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;

   always_comb begin
      next_prdata = prdata;
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      if (setup) begin
         next_pready = 1'b1;
         next_prdata = SSE_RDATA_RST;
         if (!hit) begin
            next_pslverr = 1'b1;
         end else if (pwrite && !addr_ok) begin
            // A write that names another register is refused, never stored.
            next_pslverr = 1'b1;
         end else if (!pwrite) begin
            next_prdata = {16'h0000, word[hit_idx]};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= SSE_RDATA_RST;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // Sequencer.
   sse_state_t state;
   sse_state_t next_state;
   logic [1:0] next_active_entry;
   logic [3:0] next_chan_a;
   logic [3:0] next_chan_b;
   logic next_sample_both;
   logic next_conv_busy;
   logic [15:0] cur_word;

   assign cur_word = word[active_entry];

   always_comb begin
      next_state = state;
      next_active_entry = active_entry;
      next_chan_a = chan_a;
      next_chan_b = chan_b;
      next_sample_both = 1'b0;
      next_conv_busy = conv_busy;
      case (state)
         SSE_ST_IDLE: begin
            if (conv_start) begin
               // Selections are frozen here, so a later step cannot disturb this conversion.
               next_chan_a = cur_word[SSE_CHA_HI:SSE_CHA_LO];
               next_chan_b = cur_word[SSE_CHB_HI:SSE_CHB_LO];
               next_sample_both = 1'b1;
               next_conv_busy = 1'b1;
               next_state = SSE_ST_CONV;
            end
         end
         SSE_ST_CONV: begin
            if (conv_done) begin
               if (cur_word[SSE_RET_BIT]) begin
                  next_active_entry = SSE_PTR_FIRST;
               end else begin
                  // Past entry 31 the pointer wraps to entry 28.
                  next_active_entry = 2'(active_entry + 2'h1);
               end
               next_conv_busy = 1'b0;
               next_state = SSE_ST_IDLE;
            end
         end
         default: begin
            next_state = SSE_ST_IDLE;
            next_conv_busy = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= SSE_ST_IDLE;
         active_entry <= SSE_PTR_FIRST;
         chan_a <= 4'h0;
         chan_b <= 4'h0;
         sample_both <= 1'b0;
         conv_busy <= 1'b0;
      end else begin
         state <= next_state;
         active_entry <= next_active_entry;
         chan_a <= next_chan_a;
         chan_b <= next_chan_b;
         sample_both <= next_sample_both;
         conv_busy <= next_conv_busy;
      end
   end

   // Checks on the bus side.
   a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      setup |=> pready ##1 !pready)
      else $error("answer not a single cycle");

   a_ready_cause: assert property (@(posedge pclk) disable iff (!presetn)
      pready |-> $past(setup))
      else $error("answer without a setup cycle");

   // The slave never inserts wait states, so every access cycle must complete.
   a_access_ready: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable) |-> pready)
      else $error("access cycle without answer");

   a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("error shown outside the answer cycle");

   a_unmapped_read: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && !hit) |=> pslverr && prdata == SSE_RDATA_RST)
      else $error("unmapped read not refused");

   a_unmapped_write: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && pwrite && !hit) |=> pslverr)
      else $error("unmapped write not refused");

   a_decode_top: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == SSE_ADDR_E31)
      |=> pready && !pslverr && prdata[15:0] == word[3])
      else $error("entry 31 not decoded");

   // Read data is judged against the entry decoded in the setup cycle, as it stands in the answer cycle.
   a_read_data: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && hit)
      |=> !pslverr && prdata == {16'h0000, word[$past(hit_idx)]})
      else $error("read data wrong");

   a_prdata_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !setup |=> $stable(prdata))
      else $error("read data changed outside an answer");

   a_foreign_addr: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && (pwdata[SSE_ADDR_HI:SSE_ADDR_LO] != paddr[7:2]))
      |-> pslverr)
      else $error("write with foreign address accepted");

   a_read_frame_kept: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && hit && !pwdata[SSE_DIR_BIT] && hit_idx == 2'h0)
      |=> $stable(word[0]))
      else $error("read frame altered an entry");

   a_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && hit && wr_frame && addr_ok)
      |=> word[$past(hit_idx)][SSE_RET_BIT:0] == $past(pwdata[SSE_RET_BIT:0]))
      else $error("accepted write not stored");

   a_no_stray_write: assert property (@(posedge pclk) disable iff (!presetn)
      !(access && pwrite) |=> $stable(word[0]) && $stable(word[1])
                              && $stable(word[2]) && $stable(word[3]))
      else $error("entry changed without a write");

   a_other_entry_kept: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && hit_idx != 2'h3) |=> $stable(word[3]))
      else $error("write reached the wrong entry");

   // The self address bits are fixed, so a store can never move an entry.
   a_fixed_bits: assert property (@(posedge pclk) disable iff (!presetn)
      word[0][SSE_DIR_BIT:SSE_ADDR_LO] == {1'b0, SSE_IDX_E28}
      && word[1][SSE_DIR_BIT:SSE_ADDR_LO] == {1'b0, SSE_IDX_E29}
      && word[2][SSE_DIR_BIT:SSE_ADDR_LO] == {1'b0, SSE_IDX_E30}
      && word[3][SSE_DIR_BIT:SSE_ADDR_LO] == {1'b0, SSE_IDX_E31})
      else $error("entry address bits wrong");

   a_reset_words: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> word[0] == SSE_RST_E28 && word[1] == SSE_RST_E29
                         && word[2] == SSE_RST_E30 && word[3] == SSE_RST_E31)
      else $error("entry reset value wrong");

   a_first_after_reset: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> active_entry == SSE_PTR_FIRST && !conv_busy && !pready)
      else $error("state not cleared by reset");

   // Checks on the sequencer.
   a_step_next: assert property (@(posedge pclk) disable iff (!presetn)
      (state == SSE_ST_CONV && conv_done && !cur_word[SSE_RET_BIT])
      |=> active_entry == 2'($past(active_entry) + 2'h1))
      else $error("sequencer did not advance");

   a_wrap_last: assert property (@(posedge pclk) disable iff (!presetn)
      (state == SSE_ST_CONV && conv_done && active_entry == 2'h3 && !cur_word[SSE_RET_BIT])
      |=> active_entry == SSE_PTR_FIRST)
      else $error("sequencer did not wrap after entry 31");

   // Between steps the pointer must hold, or the host would read a moving target.
   a_step_only_done: assert property (@(posedge pclk) disable iff (!presetn)
      !(state == SSE_ST_CONV && conv_done) |=> $stable(active_entry))
      else $error("sequencer stepped without a done");

   a_done_ends: assert property (@(posedge pclk) disable iff (!presetn)
      (state == SSE_ST_CONV && conv_done) |=> !conv_busy && !sample_both)
      else $error("conversion not ended by done");

   a_step_return: assert property (@(posedge pclk) disable iff (!presetn)
      (state == SSE_ST_CONV && conv_done && cur_word[SSE_RET_BIT])
      |=> (active_entry == SSE_PTR_FIRST) && !conv_busy)
      else $error("sequencer did not return");

   a_chan_b_src: assert property (@(posedge pclk) disable iff (!presetn)
      (state == SSE_ST_IDLE && conv_start)
      |=> sample_both && chan_b == $past(cur_word[SSE_CHB_HI:SSE_CHB_LO]))
      else $error("converter B channel wrong");

   a_chan_a_src: assert property (@(posedge pclk) disable iff (!presetn)
      (state == SSE_ST_IDLE && conv_start)
      |=> sample_both && chan_a == $past(cur_word[SSE_CHA_HI:SSE_CHA_LO]))
      else $error("converter A channel wrong");

   // A second pulse in one conversion would pair results from two instants.
   a_pair_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      sample_both |-> conv_busy ##1 !sample_both)
      else $error("sample pulse malformed");

   a_pulse_source: assert property (@(posedge pclk) disable iff (!presetn)
      sample_both |-> $past(state == SSE_ST_IDLE && conv_start))
      else $error("sample pulse without a start");

   a_busy_rise: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(conv_busy) |-> sample_both)
      else $error("conversion began without sampling");

   a_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      (state == SSE_ST_IDLE && !conv_start) |=> !conv_busy && !sample_both)
      else $error("sampling while idle");

   // Selections must not drift between conversions either.
   a_idle_steady: assert property (@(posedge pclk) disable iff (!presetn)
      (state == SSE_ST_IDLE && !conv_start) |=> $stable(chan_a) && $stable(chan_b))
      else $error("selection changed while idle");

   a_sel_held: assert property (@(posedge pclk) disable iff (!presetn)
      (conv_busy && $past(conv_busy)) |-> $stable(chan_a) && $stable(chan_b))
      else $error("selection changed during conversion");

endmodule

// [logic/sse_entry.sv]
// One sequence stack entry: stored low fields plus its fixed self address.
// Assumes the bank qualifies every write before raising the strobe.
`timescale 1ns/100ps
module sse_entry #(
   parameter logic [5:0] SELF_ADDR = 6'h3c
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Link to the bank.
   sse_entry_if.store port
);
   import sse_pkg::*;

   logic [8:0] low;
   logic [8:0] next_low;

   always_comb begin
      next_low = low;
      if (port.wr) begin
         next_low = port.wdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low <= SSE_LOW_RST;
      end else begin
         low <= next_low;
      end
   end

   // The direction bit reads as zero, so a readback never looks like a write frame.
   assign port.word = {1'b0, SELF_ADDR, low};
endmodule

// [logic/sse_entry_if.sv]
// Carrier between the bank and one stack entry register.
// Assumes the bank drives the write strobe and data for one cycle per write.
`timescale 1ns/100ps
interface sse_entry_if;
   logic wr;
   logic [8:0] wdata;
   logic [15:0] word;

   modport store (input wr, input wdata, output word);
   modport ctl (output wr, output wdata, input word);
endinterface

// [logic/sse_pkg.sv]
// Constants shared by the sequence stack entry bank and its entry registers.
// Assumes an APB master with 32-bit data and byte addresses on an 8-bit bus.
package sse_pkg;

   // Word layout of one stack entry.
   localparam int SSE_WORD_W = 16;
   localparam int SSE_DIR_BIT = 15;
   localparam int SSE_ADDR_HI = 14;
   localparam int SSE_ADDR_LO = 9;
   localparam int SSE_RET_BIT = 8;
   localparam int SSE_CHB_HI = 7;
   localparam int SSE_CHB_LO = 4;
   localparam int SSE_CHA_HI = 3;
   localparam int SSE_CHA_LO = 0;
   localparam int SSE_LOW_W = 9;
   localparam int SSE_NUM_ENTRIES = 4;

   // Register indices; the byte address is four times the index.
   localparam logic [5:0] SSE_IDX_E28 = 6'h3c;
   localparam logic [5:0] SSE_IDX_E29 = 6'h3d;
   localparam logic [5:0] SSE_IDX_E30 = 6'h3e;
   localparam logic [5:0] SSE_IDX_E31 = 6'h3f;
   localparam logic [7:0] SSE_ADDR_E28 = {SSE_IDX_E28, 2'h0};
   localparam logic [7:0] SSE_ADDR_E29 = {SSE_IDX_E29, 2'h0};
   localparam logic [7:0] SSE_ADDR_E30 = {SSE_IDX_E30, 2'h0};
   localparam logic [7:0] SSE_ADDR_E31 = {SSE_IDX_E31, 2'h0};

   // Reset values.
   localparam logic [8:0] SSE_LOW_RST = 9'h000;
   localparam logic [15:0] SSE_RST_E28 = 16'h7800;
   localparam logic [15:0] SSE_RST_E29 = 16'h7a00;
   localparam logic [15:0] SSE_RST_E30 = 16'h7c00;
   localparam logic [15:0] SSE_RST_E31 = 16'h7e00;
   localparam logic [1:0] SSE_PTR_FIRST = 2'h0;
   localparam logic [31:0] SSE_RDATA_RST = 32'h0000_0000;

   typedef enum logic [0:0] {
      SSE_ST_IDLE = 1'b0,
      SSE_ST_CONV = 1'b1
   } sse_state_t;

endpackage

// [testbench/sequencer_stack_entries_bench.sv]
// Bench for the sequence stack entries: APB access and sequencer stepping.
// Assumes the bank answers APB within a few cycles and a converter model.
`timescale 1ns/100ps
module sequencer_stack_entries_bench;
   import sse_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, conv_start, conv_done;
   logic pready, pslverr, sample_both, conv_busy, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] chan_a, chan_b;
   logic [1:0] active_entry;
   logic [5:0] conv_dly;
   logic [8:0] lv [4];
   int n_errors = 0;
   int num_checks = 0;

   sse_bank uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .conv_start(conv_start),
      .conv_done(conv_done), .sample_both(sample_both), .chan_a(chan_a),
      .chan_b(chan_b), .conv_busy(conv_busy), .active_entry(active_entry));
   sse_conv_model conv_side (.pclk(pclk), .presetn(presetn),
      .sample_both(sample_both), .dly(conv_dly), .conv_done(conv_done));

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   task report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task chk(input logic [31:0] s, input logic [31:0] x);
      num_checks++;
      if (s !== x) begin
         n_errors++;
         $display("FAIL t=%0t seen %h expected %h", $time, s, x);
      end
   endtask

   task guard(input int k, input int lim);
      if (k >= lim) begin
         n_errors++;
         $display("FAIL t=%0t wait ran out", $time);
         report_and_stop();
      end
   endtask

   function automatic logic [7:0] ad(int i);
      return {6'(SSE_IDX_E28 + i), 2'h0};
   endfunction

   function automatic logic [31:0] word(int i, logic [8:0] low);
      return {17'h0, 6'(SSE_IDX_E28 + i), low};
   endfunction

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      guard(k, 16);
   endtask

   task conv(input logic [3:0] a, input logic [3:0] b, input logic [1:0] nxt,
             input logic [5:0] dly);
      int k;
      @(posedge pclk);
      conv_dly <= dly;
      conv_start <= 1'b1;
      @(posedge pclk);
      conv_start <= 1'b0;
      k = 0;
      while (sample_both !== 1'b1 && k < 8) begin
         @(posedge pclk);
         k++;
      end
      guard(k, 8);
      chk(chan_a, a);
      chk(chan_b, b);
      chk(conv_busy, 1);
      k = 0;
      while (conv_busy !== 1'b0 && k < 80) begin
         @(posedge pclk);
         k++;
      end
      guard(k, 80);
      chk(active_entry, nxt);
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      conv_start = 1'b0;
      conv_dly = 6'h01;
      lv = '{9'h021, 9'h043, 9'h165, 9'h087};
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, ad(i), 32'h0, rd, er);
         chk(rd, word(i, 9'h000));
      end
      $display("test reset values done");
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, ad(i), word(i, lv[i]) | 32'h8000, rd, er);
         chk(er, 0);
      end
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, ad(i), 32'h0, rd, er);
         chk(rd, word(i, lv[i]));
      end
      apb(1'b1, ad(0), word(1, 9'h1ff) | 32'h8000, rd, er);
      chk(er, 1);
      apb(1'b1, ad(0), word(0, 9'h1ff), rd, er);
      chk(er, 0);
      apb(1'b0, ad(0), 32'h0, rd, er);
      chk(rd, word(0, lv[0]));
      apb(1'b0, 8'h00, 32'h0, rd, er);
      chk(er, 1);
      chk(rd, 0);
      apb(1'b1, 8'h00, 32'h8000, rd, er);
      chk(er, 1);
      $display("test register access done");
      conv(4'h1, 4'h2, 2'h1, 6'h00);
      conv(4'h3, 4'h4, 2'h2, 6'h05);
      conv(4'h5, 4'h6, 2'h0, 6'h01);
      apb(1'b1, ad(2), word(2, 9'h065) | 32'h8000, rd, er);
      fork
         conv(4'h1, 4'h2, 2'h1, 6'h1e);
         begin
            repeat (6) @(posedge pclk);
            apb(1'b1, ad(0), word(0, 9'h0ff) | 32'h8000, rd, er);
            repeat (2) @(posedge pclk);
            chk(chan_a, 4'h1);
            chk(chan_b, 4'h2);
         end
      join
      conv(4'h3, 4'h4, 2'h2, 6'h00);
      conv(4'h5, 4'h6, 2'h3, 6'h02);
      conv(4'h7, 4'h8, 2'h0, 6'h03);
      conv(4'hf, 4'hf, 2'h1, 6'h00);
      $display("test sequencer done");
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, ad(i), 32'h0, rd, er);
         chk(rd, word(i, 9'h000));
      end
      chk(active_entry, 2'h0);
      $display("test mid-run reset done");
      report_and_stop();
   end
endmodule

// [testbench/sse_conv_model.sv]
// Converter timing model: answers each sampling pulse with a done pulse.
// Assumes sample_both is a one-cycle pulse; the bench sets the delay.
`timescale 1ns/100ps
module sse_conv_model (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Sequencer side.
   input wire logic sample_both,
   input wire logic [5:0] dly,
   output logic conv_done
);
   logic [5:0] cnt;
   logic run;

   // A zero delay answers two cycles after sample_both rises, the fastest case.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 6'h00;
         run <= 1'b0;
         conv_done <= 1'b0;
      end else begin
         conv_done <= 1'b0;
         if (sample_both) begin
            run <= 1'b1;
            cnt <= dly;
         end else if (run && cnt == 6'h00) begin
            run <= 1'b0;
            conv_done <= 1'b1;
         end else if (run) begin
            cnt <= cnt - 6'h01;
         end
      end
   end
endmodule
